// >>> rtl/sie_pkg.sv
// Notes on behaviour
// - transmit-select set: data interrupt comes from transmit side, threshold chooses
// - transmit interrupt counts bytes sent, not bytes held in the FIFO
// - status read clears transmit flag, status bit 5
// - transmit suppression bit blocks the transmit interrupt
// - any control write restarts the transmitted-byte count at zero
// - threshold n fires every n+1 bytes, at FIFO-to-shift move
// - transmit-select clear: receive interrupt, flag bit 6, cleared by status read
// - receive interrupt judged only on a byte written into receive FIFO
// - receive interrupt fires when FIFO level reaches threshold plus one
// - receive-discard bit blocks the receive interrupt
// - transfer start with empty transmit FIFO sets underrun bit 4, interrupts
// - byte into full receive FIFO sets overflow bit 7, interrupts
// - status read or disable clears all; flushes clear their data flag
// - open-drain mode drives only zeros, releases the line for ones
// - bit counter wraps after eight clocks; early deselect sets abort bit 12
// - early deselect leaves bit counter where it stopped, resumes later
// - abort detected when select rises while counter is not 7
// - select-abort raises the interrupt whatever transmit-select says
// - status bit 0 mirrors the combined interrupt line
// - byte events arrive after last edge or next first edge / deselect
// - status read clears the select-abort flag
package sie_pkg;
  localparam int unsigned STA_W     = 16;
  localparam int unsigned STA_IRQ   = 0;
  localparam int unsigned STA_UF    = 4;
  localparam int unsigned STA_TX    = 5;
  localparam int unsigned STA_RX    = 6;
  localparam int unsigned STA_OF    = 7;
  localparam int unsigned STA_SELECT_ABORT_ERROR = 12;
  localparam logic [15:0] STA_RESET = 16'h0000;
  localparam int unsigned THR_W     = 2;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned BIT_W     = 3;
  localparam logic [2:0]  BIT_RESET = 3'h7;
  localparam logic [2:0]  BIT_LAST  = 3'h0;
  localparam logic [2:0]  BIT_STEP  = 3'h1;
  localparam logic [1:0]  TXC_ZERO  = 2'h0;
  localparam logic [1:0]  TXC_STEP  = 2'h1;
endpackage : sie_pkg

// >>> rtl/sie_irq_select_abort_error.sv
`timescale 1ns/100ps
module sie_irq_select_abort_error (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        enable_i,
  input  wire logic        tx_irq_select_i,
  input  wire logic [1:0]  irq_threshold_i,
  input  wire logic        tx_suppress_i,
  input  wire logic        rx_discard_i,
  input  wire logic        open_drain_data_mode_i,
  input  wire logic        ctl_write_i,
  input  wire logic        status_read_i,
  input  wire logic        tx_flush_i,
  input  wire logic        rx_flush_i,
  input  wire logic        xfer_start_i,
  input  wire logic        tx_fifo_empty_i,
  input  wire logic        tx_load_i,
  input  wire logic        rx_write_i,
  input  wire logic        rx_full_i,
  input  wire logic [2:0]  rx_level_i,
  input  wire logic        serial_clock_line_i,
  input  wire logic        select_n_i,
  input  wire logic        tx_bit_i,
  output logic [15:0]      status_o,
  output logic             irq_o,
  output logic [2:0]       bit_count_o,
  output logic             data_o,
  output logic             data_oe_n_o
);

  // reference-clock state
  typedef struct packed {
    logic        sel_meta;
    logic        sel_sync;
    logic        sel_prev;
    logic        home_meta;
    logic        home_sync;
    logic [1:0]  tx_cnt;
    logic [15:0] status;
  } sie_ref_t;

  // link-clock state
  typedef struct packed {
    logic        en_meta;
    logic        en_sync;
    logic        od_meta;
    logic        od_sync;
    logic [2:0]  bit_cnt;
    logic        home;
    logic        data;
    logic        oe_n;
  } sie_link_t;

  localparam sie_ref_t REF_RESET = '{
    sel_meta:  1'b1,
    sel_sync:  1'b1,
    sel_prev:  1'b1,
    home_meta: 1'b1,
    home_sync: 1'b1,
    tx_cnt:    sie_pkg::TXC_ZERO,
    status:    sie_pkg::STA_RESET
  };

  localparam sie_link_t LINK_RESET = '{
    en_meta: 1'b0,
    en_sync: 1'b0,
    od_meta: 1'b0,
    od_sync: 1'b0,
    bit_cnt: sie_pkg::BIT_RESET,
    home:    1'b1,
    data:    1'b1,
    oe_n:    1'b1
  };

  sie_ref_t  st;
  sie_ref_t  next_st;
  sie_link_t lk;
  sie_link_t next_lk;

  logic       tx_fire;
  logic       rx_fire;
  logic       uf_fire;
  logic       of_fire;
  logic       abort_fire;
  logic       sel_rise;
  logic [1:0] tx_base;
  logic [15:0] set_m;
  logic [15:0] clr_m;
  logic [15:0] flags;

  always_comb begin
    next_st = st;
    next_st.sel_meta  = select_n_i;
    next_st.sel_sync  = st.sel_meta;
    next_st.sel_prev  = st.sel_sync;
    next_st.home_meta = lk.home;
    next_st.home_sync = st.home_meta;

    // write restarts count; a load in the same cycle is the first byte
    tx_base = ctl_write_i ? sie_pkg::TXC_ZERO : st.tx_cnt;
    tx_fire = 1'b0;
    next_st.tx_cnt = tx_base;
    if (tx_load_i) begin
      if (tx_base == irq_threshold_i) begin
        tx_fire = tx_irq_select_i && !tx_suppress_i;
        next_st.tx_cnt = sie_pkg::TXC_ZERO;
      end else begin
        next_st.tx_cnt = tx_base + sie_pkg::TXC_STEP;
      end
    end
    if (tx_flush_i) begin
      next_st.tx_cnt = sie_pkg::TXC_ZERO;
    end

    // level after the write compared with threshold plus one
    rx_fire = rx_write_i && !tx_irq_select_i && !rx_discard_i
              && (rx_level_i > {1'b0, irq_threshold_i});
    uf_fire = xfer_start_i && tx_fifo_empty_i && !tx_suppress_i;
    of_fire = rx_write_i && rx_full_i && !rx_discard_i;
    sel_rise = st.sel_sync && !st.sel_prev;
    abort_fire = sel_rise && !st.home_sync;

    set_m = '0;
    set_m[sie_pkg::STA_TX]    = tx_fire;
    set_m[sie_pkg::STA_RX]    = rx_fire;
    set_m[sie_pkg::STA_UF]    = uf_fire;
    set_m[sie_pkg::STA_OF]    = of_fire;
    set_m[sie_pkg::STA_SELECT_ABORT_ERROR] = abort_fire;

    clr_m = '0;
    if (status_read_i) begin
      clr_m[sie_pkg::STA_TX]    = 1'b1;
      clr_m[sie_pkg::STA_RX]    = 1'b1;
      clr_m[sie_pkg::STA_UF]    = 1'b1;
      clr_m[sie_pkg::STA_OF]    = 1'b1;
      clr_m[sie_pkg::STA_SELECT_ABORT_ERROR] = 1'b1;
    end
    if (tx_flush_i) begin
      clr_m[sie_pkg::STA_TX] = 1'b1;
    end
    if (rx_flush_i) begin
      clr_m[sie_pkg::STA_RX] = 1'b1;
    end

    // set beats clear; disable clears everything
    flags = (st.status & ~clr_m) | set_m;
    flags[sie_pkg::STA_IRQ] = 1'b0;
    if (!enable_i) begin
      flags = '0;
    end
    next_st.status = flags;
    next_st.status[sie_pkg::STA_IRQ] = |flags;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= REF_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    next_lk = lk;
    next_lk.en_meta = enable_i;
    next_lk.en_sync = lk.en_meta;
    next_lk.od_meta = open_drain_data_mode_i;
    next_lk.od_sync = lk.od_meta;
    if (!lk.en_sync) begin
      next_lk.bit_cnt = sie_pkg::BIT_RESET;
      next_lk.data    = 1'b1;
      next_lk.oe_n    = 1'b1;
    end else begin
      // no edges while deselected: count holds where it stopped
      if (!select_n_i) begin
        if (lk.bit_cnt == sie_pkg::BIT_LAST) begin
          next_lk.bit_cnt = sie_pkg::BIT_RESET;
        end else begin
          next_lk.bit_cnt = lk.bit_cnt - sie_pkg::BIT_STEP;
        end
      end
      if (lk.od_sync) begin
        next_lk.data = 1'b0;
        next_lk.oe_n = tx_bit_i;
      end else begin
        next_lk.data = tx_bit_i;
        next_lk.oe_n = 1'b0;
      end
    end
    // counter position crosses to the reference side as one settled bit
    next_lk.home = (next_lk.bit_cnt == sie_pkg::BIT_RESET);
  end

  always_ff @(posedge serial_clock_line_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk <= LINK_RESET;
    end else begin
      lk <= next_lk;
    end
  end

  assign status_o    = st.status;
  assign irq_o       = st.status[sie_pkg::STA_IRQ];
  assign bit_count_o = lk.bit_cnt;
  assign data_o      = lk.data;
  assign data_oe_n_o = lk.oe_n;

  tx_thresh_fire_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tx_load_i && !ctl_write_i && enable_i && tx_irq_select_i
    && !tx_suppress_i && !tx_flush_i && (st.tx_cnt == irq_threshold_i)
    |=> status_o[sie_pkg::STA_TX] && (st.tx_cnt == sie_pkg::TXC_ZERO))
    else $error("transmit threshold did not fire");

  tx_rise_cause_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(status_o[sie_pkg::STA_TX])
    |-> $past(tx_load_i && tx_irq_select_i && !tx_suppress_i))
    else $error("transmit flag rose without an allowed byte load");

  read_clear_tx_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    status_read_i && !tx_load_i
    |=> !status_o[sie_pkg::STA_TX]
        && (!status_o[sie_pkg::STA_SELECT_ABORT_ERROR] || $past(abort_fire))
        && (!status_o[sie_pkg::STA_UF] || $past(xfer_start_i)))
    else $error("status read left flags set");

  rx_level_fire_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_write_i && enable_i && !tx_irq_select_i && !rx_discard_i
    && !rx_flush_i && (rx_level_i > {1'b0, irq_threshold_i})
    |=> status_o[sie_pkg::STA_RX] ##0 irq_o)
    else $error("receive level interrupt missing");

  rx_only_write_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(status_o[sie_pkg::STA_RX]) |-> $past(rx_write_i && !rx_discard_i))
    else $error("receive flag rose without a byte arriving");

  underrun_set_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    xfer_start_i && tx_fifo_empty_i && !tx_suppress_i && enable_i
    |=> status_o[sie_pkg::STA_UF] && irq_o)
    else $error("underrun not flagged");

  overflow_set_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_write_i && rx_full_i && !rx_discard_i && enable_i
    |=> status_o[sie_pkg::STA_OF] && irq_o)
    else $error("overflow not flagged");

  disable_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !enable_i [*2] |-> (status_o == sie_pkg::STA_RESET) && !irq_o)
    else $error("disable did not clear interrupts");

  abort_flag_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    st.sel_sync && !st.sel_prev && !st.home_sync && enable_i
    |=> status_o[sie_pkg::STA_SELECT_ABORT_ERROR] ##0 irq_o)
    else $error("select abort not flagged");

  set_wins_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    status_read_i && enable_i && rx_write_i && rx_full_i && !rx_discard_i
    |=> status_o[sie_pkg::STA_OF])
    else $error("event lost to a clearing read");

  open_drain_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    lk.en_sync && lk.od_sync |=> !data_o && (data_oe_n_o == $past(tx_bit_i)))
    else $error("open-drain output drove a one");

  bit_wrap_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    lk.en_sync && !select_n_i && (lk.bit_cnt == sie_pkg::BIT_LAST)
    |=> bit_count_o == sie_pkg::BIT_RESET)
    else $error("bit counter did not wrap after eight clocks");

  tx_ctl_restart_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ctl_write_i && !tx_load_i |=> st.tx_cnt == sie_pkg::TXC_ZERO)
    else $error("control write did not restart the byte count");

  tx_count_step_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tx_load_i && !ctl_write_i && !tx_flush_i
    && (st.tx_cnt != irq_threshold_i)
    |=> st.tx_cnt == $past(st.tx_cnt) + sie_pkg::TXC_STEP)
    else $error("transmitted-byte count did not step");

  tx_flush_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tx_flush_i && !tx_load_i
    |=> !status_o[sie_pkg::STA_TX] && (st.tx_cnt == sie_pkg::TXC_ZERO))
    else $error("transmit flush left the flag or count set");

  rx_flush_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_flush_i && !rx_write_i |=> !status_o[sie_pkg::STA_RX])
    else $error("receive flush left the flag set");

  discard_block_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rx_discard_i && !status_o[sie_pkg::STA_RX] && !status_o[sie_pkg::STA_OF]
    |=> !status_o[sie_pkg::STA_RX] && !status_o[sie_pkg::STA_OF])
    else $error("receive-discard did not block the receive side");

  suppress_block_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tx_suppress_i && !status_o[sie_pkg::STA_TX] && !status_o[sie_pkg::STA_UF]
    |=> !status_o[sie_pkg::STA_TX] && !status_o[sie_pkg::STA_UF])
    else $error("transmit suppression did not block the transmit side");

  rx_sel_block_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    tx_irq_select_i && !status_o[sie_pkg::STA_RX]
    |=> !status_o[sie_pkg::STA_RX])
    else $error("receive interrupt set in transmit-select mode");

  tx_sel_block_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !tx_irq_select_i && !status_o[sie_pkg::STA_TX]
    |=> !status_o[sie_pkg::STA_TX])
    else $error("transmit interrupt set in receive-select mode");

  irq_mirror_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    irq_o == (status_o[sie_pkg::STA_UF] || status_o[sie_pkg::STA_TX]
              || status_o[sie_pkg::STA_RX] || status_o[sie_pkg::STA_OF]
              || status_o[sie_pkg::STA_SELECT_ABORT_ERROR]))
    else $error("interrupt line differs from the status flags");

  abort_cause_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(status_o[sie_pkg::STA_SELECT_ABORT_ERROR]) |-> $past(sel_rise && !st.home_sync))
    else $error("select-abort flag rose without an early deselect");

  count_hold_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    lk.en_sync && select_n_i |=> $stable(bit_count_o))
    else $error("bit counter moved while deselected");

  count_step_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    lk.en_sync && !select_n_i && (lk.bit_cnt != sie_pkg::BIT_LAST)
    |=> bit_count_o == $past(bit_count_o) - sie_pkg::BIT_STEP)
    else $error("bit counter did not step down");

  link_off_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    !lk.en_sync |=> (bit_count_o == sie_pkg::BIT_RESET) && data_oe_n_o)
    else $error("disabled link did not return to rest");

  push_pull_a: assert property (
    @(posedge serial_clock_line_i) disable iff (!reset_n_i)
    lk.en_sync && !lk.od_sync
    |=> !data_oe_n_o && (data_o == $past(tx_bit_i)))
    else $error("push-pull output did not follow the data");

endmodule : sie_irq_select_abort_error

// >>> dv/sie_link_model.sv
`timescale 1ns/100ps
module sie_link_model (
  output logic      serial_clock_o,
  output logic      select_n_o,
  input  wire logic data_i,
  input  wire logic data_oe_n_i,
  output logic      line_o,
  output logic      line_and_o,
  output logic      line_or_o
);
  // released line floats up through the pull-up
  assign line_o = data_oe_n_i ? 1'b1 : data_i;

  initial begin
    serial_clock_o = 1'b0;
    select_n_o = 1'b1;
    line_and_o = 1'b1;
    line_or_o = 1'b0;
  end

  // clock runs only while selected; n below the bits left in the current byte aborts it
  task frame(input int n);
    line_and_o = 1'b1;
    line_or_o = 1'b0;
    #13 select_n_o = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      serial_clock_o = 1'b1;
      #80 serial_clock_o = 1'b0;
      if (i >= 3) begin
        line_and_o = line_and_o & line_o;
        line_or_o = line_or_o | line_o;
      end
      #80;
    end
    select_n_o = 1'b1;
    #80;
  endtask : frame
endmodule : sie_link_model

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        ref_clk_i;
  logic        reset_n_i;
  logic        enable;
  logic        tx_sel;
  logic [1:0]  thr;
  logic        tx_sup;
  logic        rx_disc;
  logic        od_mode;
  logic [6:0]  ev;
  logic        tx_empty;
  logic        rx_full;
  logic [2:0]  rx_level;
  logic        tx_bit;
  logic        sclk;
  logic        sel_n;
  logic        line_and;
  logic        line_or;
  logic [15:0] status;
  logic        irq;
  logic [2:0]  bit_count;
  logic        data;
  logic        data_oe_n;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  sie_irq_select_abort_error i_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .enable_i(enable),
    .tx_irq_select_i(tx_sel), .irq_threshold_i(thr),
    .tx_suppress_i(tx_sup), .rx_discard_i(rx_disc),
    .open_drain_data_mode_i(od_mode), .ctl_write_i(ev[0]),
    .status_read_i(ev[1]), .tx_flush_i(ev[2]), .rx_flush_i(ev[3]),
    .xfer_start_i(ev[4]), .tx_fifo_empty_i(tx_empty), .tx_load_i(ev[5]),
    .rx_write_i(ev[6]), .rx_full_i(rx_full), .rx_level_i(rx_level),
    .serial_clock_line_i(sclk), .select_n_i(sel_n), .tx_bit_i(tx_bit),
    .status_o(status), .irq_o(irq), .bit_count_o(bit_count),
    .data_o(data), .data_oe_n_o(data_oe_n));

  sie_link_model i_link (
    .serial_clock_o(sclk), .select_n_o(sel_n), .data_i(data),
    .data_oe_n_i(data_oe_n), .line_o(), .line_and_o(line_and),
    .line_or_o(line_or));

  task close_out;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle event pulse, bits: ctl rd txfl rxfl start load rxwr
  task pulse(input logic [6:0] m);
    ev = m;
    @(posedge ref_clk_i);
    #1;
    ev = 7'h00;
    @(posedge ref_clk_i);
    #1;
  endtask : pulse

  task idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : idle

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    reset_n_i = 1'b1;
    {enable, tx_sel, thr, tx_sup, rx_disc, od_mode} = 7'h60;
    {ev, tx_empty, rx_full, rx_level, tx_bit} = 13'h0001;
    #1;
    reset_n_i = 1'b0;
    idle(4);
    reset_n_i = 1'b1;
    chk(status, 16'h0000);
    chk({13'h0000, bit_count}, 16'h0007);
    chk({15'h0000, data_oe_n}, 16'h0001);
    for (int t = 0; t < 4; t++) begin
      thr = t[1:0];
      pulse(7'h20);
      pulse(7'h01);
      pulse(7'h02);
      repeat (t) pulse(7'h20);
      chk(status, 16'h0000);
      pulse(7'h20);
      chk(status, 16'h0021);
      chk({15'h0000, irq}, 16'h0001);
      pulse(7'h02);
      chk(status, 16'h0000);
    end
    tx_empty = 1'b1;
    pulse(7'h10);
    chk(status, 16'h0011);
    pulse(7'h02);
    thr = 2'h0;
    tx_sup = 1'b1;
    pulse(7'h30);
    chk(status, 16'h0000);
    {tx_sup, tx_empty, tx_sel, thr, rx_level} = 8'h09;
    pulse(7'h40);
    chk(status, 16'h0000);
    rx_level = 3'h2;
    pulse(7'h40);
    chk(status, 16'h0041);
    pulse(7'h02);
    idle(5);
    chk(status, 16'h0000);
    rx_level = 3'h3;
    pulse(7'h40);
    chk(status, 16'h0041);
    pulse(7'h02);
    rx_disc = 1'b1;
    pulse(7'h40);
    chk(status, 16'h0000);
    {rx_disc, thr, rx_full, rx_level} = 7'h3B;
    pulse(7'h42);
    chk(status, 16'h0081);
    enable = 1'b0;
    idle(2);
    chk(status, 16'h0000);
    enable = 1'b1; // select is high here
    {thr, rx_full, rx_level} = 6'h01;
    pulse(7'h40);
    pulse(7'h08);
    chk(status, 16'h0000);
    od_mode = 1'b1;
    // warm-up frame, then realign the counter to a byte boundary
    i_link.frame(8);
    i_link.frame(int'(bit_count) + 1);
    idle(1);
    pulse(7'h02);
    i_link.frame(8);
    idle(10);
    chk({13'h0000, bit_count}, 16'h0007);
    chk(status, 16'h0000);
    chk({15'h0000, line_and}, 16'h0001);
    chk({15'h0000, data_oe_n}, 16'h0001);
    chk({15'h0000, data}, 16'h0000);
    tx_bit = 1'b0;
    i_link.frame(8);
    chk({15'h0000, line_or}, 16'h0000);
    i_link.frame(3);
    idle(10);
    chk({13'h0000, bit_count}, 16'h0004);
    chk(status, 16'h1001);
    pulse(7'h02);
    chk(status, 16'h0000);
    i_link.frame(5);
    idle(10);
    chk({13'h0000, bit_count}, 16'h0007);
    chk(status, 16'h0000);
    od_mode = 1'b0;
    tx_bit = 1'b1;
    i_link.frame(8);
    chk({15'h0000, data_oe_n}, 16'h0000);
    chk({15'h0000, data}, 16'h0001);
    close_out();
  end
endmodule : testbench
